/* File: pst_consts.svh */
// Register offsets, field positions, reset values and timing counts of the PTP time block.
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH
`define PST_OFF_CTRL 8'h00
`define PST_OFF_STEP 8'h04
`define PST_OFF_SEC 8'h08
`define PST_OFF_SUB 8'h0C
`define PST_OFF_USEC 8'h10
`define PST_OFF_USUB 8'h14
`define PST_OFF_ADDEND 8'h18
`define PST_OFF_TSEC 8'h1C
`define PST_OFF_TSUB 8'h20
`define PST_OFF_STAT 8'h24
`define PST_CTRL_RESET 32'h0000_2000
`define PST_CTRL_WMASK 32'h0007_FF3F
`define PST_CTRL_CMDS 32'h0000_002C
`define PST_B_ON 0
`define PST_B_FINE 1
`define PST_B_LOAD 2
`define PST_B_ADJ 3
`define PST_B_ARM 4
`define PST_B_RELOAD 5
`define PST_B_EVERY 8
`define PST_B_DEC 9
`define PST_B_V2 10
`define PST_B_L2 11
`define PST_B_UDP6 12
`define PST_B_UDP4 13
`define PST_B_EVONLY 14
`define PST_B_MASTER 15
`define PST_B_CTYPE 16
`define PST_B_MACF 18
`define PST_B_SIGN 31
`define PST_B_REACHED 1
`define PST_SUB_DEC_MAX 32'h3B9A_C9FF
`define PST_SUB_BIN_MAX 32'h7FFF_FFFF
`define PST_MSG_SYNC 4'h0
`define PST_MSG_DREQ 4'h1
`define PST_MSG_PDREQ 4'h2
`define PST_MSG_PDRESP 4'h3
`define PST_MSG_FUP 4'h8
`define PST_MSG_DRESP 4'h9
`define PST_RESP_OK 2'h0
`define PST_RESP_ERR 2'h2
`define PST_REF_DIV 2
`endif

/* File: pst_pkg.sv */
// Types shared by the PTP time block.
package pst_pkg;
  typedef enum logic [1:0] {PST_ENC_NONE, PST_ENC_L2, PST_ENC_UDP4, PST_ENC_UDP6} pst_encap_t;
  typedef enum logic [1:0] {PST_CK_ORD, PST_CK_BND, PST_CK_E2E, PST_CK_P2P} pst_clk_type_t;
endpackage

/* File: pst_time_ctrl.sv */
// PTP system time keeper, snapshot selector and AXI4-Lite register file.
//
// Summary of operation
// - Stamping on enables tx and rx snapshots.
// - Stamping off halts time, ignores rx frames.
// - Load command overwrites time, then self-clears.
// - Adjust command adds or subtracts update values.
// - Fine select chooses accumulator or coarse stepping.
// - Coarse mode adds step every reference tick.
// - Fine mode steps only on accumulator overflow.
// - Reload command copies addend into time logic.
// - Rollover select: decimal or binary subsecond wrap.
// - Armed target reach raises interrupt, clears arm.
// - Every-frame bit snapshots all received frames.
// - Version select picks v2 or v1 parsing.
// - Raw Ethernet PTP processed only when enabled.
// - UDP over IPv6 PTP processed when enabled.
// - UDP over IPv4 enabled from reset.
// - Event-only bit limits snapshots to events.
// - Clock type field selects snapshot profile.
// - Per profile message sets for snapshots.
// - Master select picks master or slave messages.
// - MAC address match filters raw Ethernet PTP.
// - Target reached when time meets target; flag.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pst_consts.svh"

module pst_time_ctrl #(
  parameter int REF_DIV = `PST_REF_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxFrameValid,
  input wire pst_pkg::pst_encap_t rxPtpEncap,
  input wire logic rxPtpV2,
  input wire logic [3:0] rxMsgType,
  input wire logic rxMacAddrMatch,
  input wire logic txStampReq,
  output logic rxSnapValid,
  output logic [31:0] rxSnapSec,
  output logic [30:0] rxSnapSub,
  output logic txSnapValid,
  output logic [31:0] txSnapSec,
  output logic [30:0] txSnapSub,
  output logic stampIrq
);

  // Picks the messages that the selected clock profile stamps.
  function automatic logic msgSel(input logic [3:0] t, input logic [1:0] ct,
                                  input logic ev, input logic m);
    logic four;
    logic pd;
    four = (t == `PST_MSG_SYNC) || (t == `PST_MSG_FUP) ||
           (t == `PST_MSG_DREQ) || (t == `PST_MSG_DRESP);
    pd = (t == `PST_MSG_PDREQ) || (t == `PST_MSG_PDRESP);
    msgSel = 1'b0;
    unique case (pst_pkg::pst_clk_type_t'(ct))
      pst_pkg::PST_CK_ORD, pst_pkg::PST_CK_BND: begin
        if (!ev) msgSel = four;
        else msgSel = m ? (t == `PST_MSG_DREQ) : (t == `PST_MSG_SYNC);
      end
      pst_pkg::PST_CK_E2E: begin
        msgSel = ev ? ((t == `PST_MSG_SYNC) || (t == `PST_MSG_FUP)) : four;
      end
      pst_pkg::PST_CK_P2P: begin
        msgSel = ev ? ((t == `PST_MSG_SYNC) || pd) : (four || pd);
      end
    endcase
  endfunction

  // Applies byte enables to a register write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0] ctrl;
  logic [7:0] step;
  logic [31:0] updSec;
  logic [31:0] updSubw;
  logic [31:0] fineAddend;
  logic [31:0] activeAddend;
  logic [31:0] acc;
  logic [31:0] timeSec;
  logic [30:0] timeSub;
  logic [31:0] secShadow;
  logic [31:0] tgtSec;
  logic [31:0] tgtSub;
  logic reachedFlag;
  logic reachedPrev;
  logic [7:0] divCnt;
  logic tick;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;

  // Reference clock rate as an enable pulse.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      divCnt <= (divCnt == 8'(REF_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
      tick <= (divCnt == 8'(REF_DIV - 1));
    end
  end

  wire stampingOn = ctrl[`PST_B_ON];
  wire fineMode = ctrl[`PST_B_FINE];
  wire loadCmd = ctrl[`PST_B_LOAD];
  wire adjustCmd = ctrl[`PST_B_ADJ];
  wire targetArm = ctrl[`PST_B_ARM];
  wire reloadCmd = ctrl[`PST_B_RELOAD];
  wire [31:0] maxSub = ctrl[`PST_B_DEC] ? `PST_SUB_DEC_MAX : `PST_SUB_BIN_MAX;

  // Load and adjust wait while stamping is off; load wins over adjust.
  wire loadDo = loadCmd && stampingOn;
  wire adjDo = adjustCmd && stampingOn && !loadCmd;
  wire [32:0] accSum = {1'b0, acc} + {1'b0, activeAddend};
  wire accCarry = accSum[32];
  wire advance = stampingOn && tick && (!fineMode || accCarry);

  wire [31:0] subExt = {1'b0, timeSub};
  wire [31:0] sumT = subExt + {24'h000000, step};
  wire wrapT = sumT > maxSub;
  wire [31:0] tickSub = wrapT ? sumT - maxSub - 32'h1 : sumT;
  wire [31:0] sumA = subExt + {1'b0, updSubw[30:0]};
  wire wrapA = sumA > maxSub;
  wire [31:0] diffA = subExt - {1'b0, updSubw[30:0]};
  wire borrowA = diffA[31];
  wire subMode = updSubw[`PST_B_SIGN];
  wire [31:0] adjSub = subMode ? (borrowA ? diffA + maxSub + 32'h1 : diffA)
                               : (wrapA ? sumA - maxSub - 32'h1 : sumA);
  wire [31:0] adjSec = subMode ? timeSec - updSec - {31'h0, borrowA}
                               : timeSec + updSec + {31'h0, wrapA};

  wire reachedNow = (timeSec > tgtSec) ||
                    ((timeSec == tgtSec) && ({1'b0, timeSub} >= tgtSub));
  wire reachEvent = reachedNow && !reachedPrev;
  wire irqFire = reachEvent && targetArm && stampingOn;

  // System time, accumulator and addend transfer.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timeSec <= 32'h0000_0000;
      timeSub <= 31'h0000_0000;
      acc <= 32'h0000_0000;
      activeAddend <= 32'h0000_0000;
      reachedPrev <= 1'b0;
      stampIrq <= 1'b0;
    end else begin
      if (loadDo) begin
        timeSec <= updSec;
        timeSub <= updSubw[30:0];
      end else if (adjDo) begin
        timeSec <= adjSec;
        timeSub <= adjSub[30:0];
      end else if (advance) begin
        timeSec <= timeSec + {31'h0, wrapT};
        timeSub <= tickSub[30:0];
      end
      if (stampingOn && tick && fineMode) acc <= accSum[31:0];
      if (reloadCmd) activeAddend <= fineAddend;
      reachedPrev <= reachedNow;
      stampIrq <= irqFire;
    end
  end

  // Receive snapshot filter.
  logic encOk;
  always_comb begin
    unique case (rxPtpEncap)
      pst_pkg::PST_ENC_NONE: encOk = 1'b0;
      pst_pkg::PST_ENC_L2: encOk = ctrl[`PST_B_L2] &&
                                   (!ctrl[`PST_B_MACF] || rxMacAddrMatch);
      pst_pkg::PST_ENC_UDP4: encOk = ctrl[`PST_B_UDP4];
      pst_pkg::PST_ENC_UDP6: encOk = ctrl[`PST_B_UDP6];
    endcase
  end

  wire verOk = (rxPtpV2 == ctrl[`PST_B_V2]);
  wire ptpOk = encOk && verOk && msgSel(rxMsgType, ctrl[`PST_B_CTYPE +: 2],
                                        ctrl[`PST_B_EVONLY], ctrl[`PST_B_MASTER]);
  wire rxTake = rxFrameValid && stampingOn && (ctrl[`PST_B_EVERY] || ptpOk);
  wire txTake = txStampReq && stampingOn;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxSnapValid <= 1'b0;
      rxSnapSec <= 32'h0000_0000;
      rxSnapSub <= 31'h0000_0000;
      txSnapValid <= 1'b0;
      txSnapSec <= 32'h0000_0000;
      txSnapSub <= 31'h0000_0000;
    end else begin
      rxSnapValid <= rxTake;
      txSnapValid <= txTake;
      if (rxTake) begin
        rxSnapSec <= timeSec;
        rxSnapSub <= timeSub;
      end
      if (txTake) begin
        txSnapSec <= timeSec;
        txSnapSub <= timeSub;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order.
  wire doWrite = !awready && !wready && !bvalid;
  wire [31:0] wEff = merge(ctrl, wDataQ, wStrbQ);
  wire wrCtrl = doWrite && (awAddrQ == `PST_OFF_CTRL);
  wire wrStep = doWrite && (awAddrQ == `PST_OFF_STEP);
  wire wrUSec = doWrite && (awAddrQ == `PST_OFF_USEC);
  wire wrUSub = doWrite && (awAddrQ == `PST_OFF_USUB);
  wire wrAdd = doWrite && (awAddrQ == `PST_OFF_ADDEND);
  wire wrTSec = doWrite && (awAddrQ == `PST_OFF_TSEC);
  wire wrTSub = doWrite && (awAddrQ == `PST_OFF_TSUB);
  wire wrStat = doWrite && (awAddrQ == `PST_OFF_STAT);
  wire wrHit = wrCtrl || wrStep || wrUSec || wrUSub || wrAdd || wrTSec || wrTSub || wrStat ||
               (awAddrQ == `PST_OFF_SEC) || (awAddrQ == `PST_OFF_SUB);

  wire [31:0] wMasked = wEff & `PST_CTRL_WMASK;
  wire [31:0] ctrlBase = wrCtrl ? ((wMasked & ~`PST_CTRL_CMDS) | (ctrl & `PST_CTRL_CMDS)) : ctrl;
  wire [31:0] hwClr = {26'h0, reloadCmd, irqFire, adjDo, loadDo, 2'b00};
  wire [31:0] swSet = wrCtrl ? (wMasked & (`PST_CTRL_CMDS | (32'h1 << `PST_B_ARM))) : 32'h0;
  wire [31:0] next_ctrl = (ctrlBase & ~hwClr) | swSet;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `PST_RESP_OK;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddrQ <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? `PST_RESP_OK : `PST_RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Software registers; target flag set wins over its write-one clear.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= `PST_CTRL_RESET;
      step <= 8'h00;
      updSec <= 32'h0000_0000;
      updSubw <= 32'h0000_0000;
      fineAddend <= 32'h0000_0000;
      tgtSec <= 32'h0000_0000;
      tgtSub <= 32'h0000_0000;
      reachedFlag <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      if (wrStep && wStrbQ[0]) step <= wDataQ[7:0];
      if (wrUSec) updSec <= merge(updSec, wDataQ, wStrbQ);
      if (wrUSub) updSubw <= merge(updSubw, wDataQ, wStrbQ);
      if (wrAdd) fineAddend <= merge(fineAddend, wDataQ, wStrbQ);
      if (wrTSec) tgtSec <= merge(tgtSec, wDataQ, wStrbQ);
      if (wrTSub) tgtSub <= merge(tgtSub, wDataQ, wStrbQ);
      reachedFlag <= (reachedFlag && !(wrStat && wStrbQ[0] && wDataQ[`PST_B_REACHED])) ||
                     (reachEvent && stampingOn);
    end
  end

  // AXI4-Lite read side; a subseconds read freezes seconds for the next read.
  wire arHs = arvalid && arready;
  wire [7:0] rA = {araddr[7:2], 2'b00};
  wire rdSub = (rA == `PST_OFF_SUB);
  wire rdHit = (rA == `PST_OFF_CTRL) || (rA == `PST_OFF_STEP) || (rA == `PST_OFF_SEC) ||
               rdSub || (rA == `PST_OFF_USEC) || (rA == `PST_OFF_USUB) ||
               (rA == `PST_OFF_ADDEND) || (rA == `PST_OFF_TSEC) ||
               (rA == `PST_OFF_TSUB) || (rA == `PST_OFF_STAT);
  wire [31:0] rdMux =
    (rA == `PST_OFF_CTRL) ? ctrl :
    (rA == `PST_OFF_STEP) ? {24'h0, step} :
    (rA == `PST_OFF_SEC) ? secShadow :
    rdSub ? {1'b0, timeSub} :
    (rA == `PST_OFF_USEC) ? updSec :
    (rA == `PST_OFF_USUB) ? updSubw :
    (rA == `PST_OFF_ADDEND) ? fineAddend :
    (rA == `PST_OFF_TSEC) ? tgtSec :
    (rA == `PST_OFF_TSUB) ? tgtSub :
    (rA == `PST_OFF_STAT) ? {30'h0, reachedFlag, 1'b0} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PST_RESP_OK;
      secShadow <= 32'h0000_0000;
    end else begin
      if (arHs) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdHit ? `PST_RESP_OK : `PST_RESP_ERR;
        if (rdSub) secShadow <= timeSec;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_halt;
    !stampingOn |=> $stable(timeSec) && $stable(timeSub);
  endproperty
  a_halt: assert property (p_halt) else $error("Time moved while stamping off.");

  property p_no_snap;
    (rxSnapValid || txSnapValid) |-> $past(stampingOn);
  endproperty
  a_no_snap: assert property (p_no_snap) else $error("Snapshot while stamping off.");

  property p_load;
    loadDo && !wrCtrl |=> timeSec == $past(updSec) && timeSub == $past(updSubw[30:0]) && !loadCmd;
  endproperty
  a_load: assert property (p_load) else $error("Load did not overwrite time.");

  property p_adjust;
    adjDo && !wrCtrl |=> !adjustCmd ##1 !adjustCmd || $past(wrCtrl);
  endproperty
  a_adjust: assert property (p_adjust) else $error("Adjust bit not cleared.");

  property p_coarse;
    advance && !fineMode && !loadDo && !adjDo && !wrapT |=>
      {1'b0, timeSub} == $past(subExt) + {24'h0, $past(step)} && $stable(timeSec);
  endproperty
  a_coarse: assert property (p_coarse) else $error("Coarse step not applied.");

  property p_fine_hold;
    stampingOn && fineMode && !accCarry && !loadDo && !adjDo |=> $stable(timeSub);
  endproperty
  a_fine_hold: assert property (p_fine_hold) else $error("Fine time moved, no overflow.");

  property p_reload;
    reloadCmd && !wrCtrl |=> activeAddend == $past(fineAddend) && !reloadCmd;
  endproperty
  a_reload: assert property (p_reload) else $error("Addend reload failed.");

  property p_irq;
    stampIrq |-> !targetArm && reachedFlag && $past(reachedNow);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without reach or arm left set.");

  property p_wrap;
    advance && !loadDo && !adjDo |=> ({1'b0, timeSub} <= $past(maxSub)) || $past(subExt > maxSub);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Subseconds passed rollover value.");

endmodule // pst_time_ctrl

/* File: pst_mac_model.sv */
// Model of the MAC transmit and receive datapaths that ask for timestamp snapshots.
`timescale 1ns/1ps
module pst_mac_model (
  input wire logic clk,
  output logic rxFrameValid,
  output pst_pkg::pst_encap_t rxPtpEncap,
  output logic rxPtpV2,
  output logic [3:0] rxMsgType,
  output logic rxMacAddrMatch,
  output logic txStampReq
);
  initial begin
    rxFrameValid = 1'b0;
    rxPtpEncap = pst_pkg::PST_ENC_NONE;
    rxPtpV2 = 1'b0;
    rxMsgType = 4'h0;
    rxMacAddrMatch = 1'b0;
    txStampReq = 1'b0;
  end
  task automatic rx_frame(input logic [1:0] e, input logic v, input logic [3:0] t,
                          input logic mt);
    @(posedge clk);
    rxFrameValid <= 1'b1;
    rxPtpEncap <= pst_pkg::pst_encap_t'(e);
    rxPtpV2 <= v;
    rxMsgType <= t;
    rxMacAddrMatch <= mt;
    @(posedge clk);
    rxFrameValid <= 1'b0;
    // Outside a frame the classification lines mean nothing, so they show the inverse.
    rxPtpEncap <= pst_pkg::pst_encap_t'(~e);
    rxPtpV2 <= ~v;
    rxMsgType <= ~t;
    rxMacAddrMatch <= ~mt;
  endtask
  task automatic tx_req();
    @(posedge clk);
    txStampReq <= 1'b1;
    @(posedge clk);
    txStampReq <= 1'b0;
  endtask
endmodule // pst_mac_model

/* File: ptp_system_time_and_snapshot_ctrl_tb.sv */
// Self-checking testbench of the PTP time and snapshot block.
`timescale 1ns/1ps
`include "pst_consts.svh"
module ptp_system_time_and_snapshot_ctrl_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxFrameValid, rxPtpV2, rxMacAddrMatch;
  logic txStampReq, rxSnapValid, txSnapValid, stampIrq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rxSnapSec, txSnapSec;
  logic [30:0] rxSnapSub, txSnapSub;
  logic [3:0] rxMsgType;
  pst_pkg::pst_encap_t rxPtpEncap;
  int err_count = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  pst_time_ctrl #(.REF_DIV(1)) u_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxFrameValid(rxFrameValid), .rxPtpEncap(rxPtpEncap),
    .rxPtpV2(rxPtpV2), .rxMsgType(rxMsgType), .rxMacAddrMatch(rxMacAddrMatch),
    .txStampReq(txStampReq), .rxSnapValid(rxSnapValid), .rxSnapSec(rxSnapSec),
    .rxSnapSub(rxSnapSub), .txSnapValid(txSnapValid), .txSnapSec(txSnapSec),
    .txSnapSub(txSnapSub), .stampIrq(stampIrq));
  pst_mac_model u_mac (.clk(clk), .rxFrameValid(rxFrameValid), .rxPtpEncap(rxPtpEncap),
    .rxPtpV2(rxPtpV2), .rxMsgType(rxMsgType), .rxMacAddrMatch(rxMacAddrMatch),
    .txStampReq(txStampReq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    num_checks++;
    if (seen !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, `PST_RESP_OK});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, d, ex);
  endtask
  task automatic rx(input logic [1:0] e, input logic v, input logic [3:0] t, input logic mt,
                    input logic ex);
    u_mac.rx_frame(e, v, t, mt);
    #1;
    chk("rxSnapValid", {31'h0, rxSnapValid}, {31'h0, ex});
  endtask
  // Two transmit snapshots four reference ticks apart; their subsecond difference is checked.
  task automatic txdiff(input logic [31:0] ex);
    logic [30:0] s0;
    u_mac.tx_req();
    #1;
    chk("txSnapValid", {31'h0, txSnapValid}, 32'h1);
    s0 = txSnapSub;
    repeat (2) @(posedge clk);
    u_mac.tx_req();
    #1;
    chk("txStep", {1'b0, txSnapSub - s0}, ex);
  endtask
  function automatic logic exp_snap(logic [31:0] c, logic [1:0] e, logic v, logic [3:0] t,
                                    logic mt);
    logic p;
    logic [1:0] ct;
    ct = c[17:16];
    if (!c[0]) return 1'b0;
    if (c[8]) return 1'b1;
    case (e)
      2'd1: p = c[11] && (!c[18] || mt);
      2'd2: p = c[13];
      2'd3: p = c[12];
      default: p = 1'b0;
    endcase
    if (v !== c[10]) p = 1'b0;
    if (!c[14]) begin
      p = p && (t inside {4'h0, 4'h1, 4'h8, 4'h9} || (ct == 2'd3 && t inside {4'h2, 4'h3}));
    end else if (ct < 2'd2) p = p && (t == (c[15] ? 4'h1 : 4'h0));
    else p = p && (t == 4'h0 || (ct == 2'd2 ? t == 4'h8 : t inside {4'h2, 4'h3}));
    return p;
  endfunction
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] c;
  logic [3:0] msgs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hB};
  logic [31:0] encCtrl [5] = '{32'h2001, 32'h3801, 32'h43801, 32'h2401, 32'h2101};
  logic [31:0] adjSub [2] = '{32'h8000_0010, 32'h0000_0020};
  logic [31:0] expSub [2] = '{32'h0000_00F0, 32'h0000_0110};
  logic [31:0] expSec [2] = '{32'h3, 32'h5};
  int n;
  logic snapEx;
  logic [3:0] msgT;
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdc("ctrl", `PST_OFF_CTRL, `PST_CTRL_RESET);
    rdc("step", `PST_OFF_STEP, 32'h0);
    rdc("sub", `PST_OFF_SUB, 32'h0);
    rdc("sec", `PST_OFF_SEC, 32'h0);
    axr(8'h3C, d, r);
    chk("rresp", {30'h0, r}, {30'h0, `PST_RESP_ERR});
    chk("rdata", d, 32'h0);
    axw(8'h3C, 32'hFFFF_FFFF, r);
    chk("bresp", {30'h0, r}, {30'h0, `PST_RESP_ERR});
    rx(2'd2, 1'b0, `PST_MSG_SYNC, 1'b0, 1'b0);
    u_mac.tx_req();
    #1;
    chk("txSnapValid", {31'h0, txSnapValid}, 32'h0);
    wr(`PST_OFF_USEC, 32'h5);
    wr(`PST_OFF_USUB, 32'h100);
    rdc("ctrl", `PST_OFF_CTRL, 32'h2000);
    wr(`PST_OFF_CTRL, 32'h2005);
    rdc("ctrl", `PST_OFF_CTRL, 32'h2001);
    rdc("sub", `PST_OFF_SUB, 32'h100);
    rdc("sec", `PST_OFF_SEC, 32'h5);
    for (int i = 0; i < 2; i++) begin
      wr(`PST_OFF_USEC, 32'h2);
      wr(`PST_OFF_USUB, adjSub[i]);
      wr(`PST_OFF_CTRL, 32'h2009);
      rdc("ctrl", `PST_OFF_CTRL, 32'h2001);
      rdc("sub", `PST_OFF_SUB, expSub[i]);
      rdc("sec", `PST_OFF_SEC, expSec[i]);
    end
    wr(`PST_OFF_STEP, 32'h10);
    txdiff(32'h40);
    wr(`PST_OFF_ADDEND, 32'h8000_0000);
    wr(`PST_OFF_CTRL, 32'h2023);
    rdc("ctrl", `PST_OFF_CTRL, 32'h2003);
    txdiff(32'h20);
    wr(`PST_OFF_STEP, 32'h20);
    for (int k = 0; k < 2; k++) begin
      wr(`PST_OFF_USEC, 32'h7);
      wr(`PST_OFF_USUB, (k ? `PST_SUB_DEC_MAX : `PST_SUB_BIN_MAX) - 32'hF);
      wr(`PST_OFF_CTRL, 32'h2005 | (32'(k) << `PST_B_DEC));
      repeat (10) @(posedge clk);
      axr(`PST_OFF_SUB, d, r);
      chk("wrapSub", {31'h0, d < 32'h400}, 32'h1);
      rdc("wrapSec", `PST_OFF_SEC, 32'h8);
    end
    wr(`PST_OFF_TSEC, 32'h20);
    wr(`PST_OFF_TSUB, 32'h800);
    wr(`PST_OFF_USEC, 32'h20);
    wr(`PST_OFF_USUB, 32'h0);
    wr(`PST_OFF_STEP, 32'h10);
    wr(`PST_OFF_CTRL, 32'h2005);
    wr(`PST_OFF_STAT, 32'h2);
    rdc("status", `PST_OFF_STAT, 32'h0);
    wr(`PST_OFF_CTRL, 32'h2011);
    n = 0;
    while (stampIrq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("stampIrq", {31'h0, stampIrq}, 32'h1);
    rdc("ctrl", `PST_OFF_CTRL, 32'h2001);
    rdc("status", `PST_OFF_STAT, 32'h2);
    wr(`PST_OFF_STEP, 32'h0);
    // With a zero step the loaded time stays frozen, so every snapshot must carry it.
    wr(`PST_OFF_USEC, 32'h1234);
    wr(`PST_OFF_USUB, 32'h5678);
    wr(`PST_OFF_CTRL, 32'h2005);
    for (int ct = 0; ct < 4; ct++) begin
      for (int em = 0; em < 4; em++) begin
        c = 32'h2001 | (32'(ct) << 16) | (32'(em) << 14);
        wr(`PST_OFF_CTRL, c);
        foreach (msgs[j]) begin
          snapEx = exp_snap(c, 2'd2, 1'b0, msgs[j], 1'b0);
          rx(2'd2, 1'b0, msgs[j], 1'b0, snapEx);
        end
      end
    end
    chk("rxSnapSec", rxSnapSec, 32'h1234);
    chk("rxSnapSub", {1'b0, rxSnapSub}, 32'h5678);
    u_mac.tx_req();
    #1;
    chk("txSnapSec", txSnapSec, 32'h1234);
    chk("txSnapSub", {1'b0, txSnapSub}, 32'h5678);
    foreach (encCtrl[i]) begin
      c = encCtrl[i];
      wr(`PST_OFF_CTRL, c);
      for (int q = 0; q < 16; q++) begin
        msgT = c[8] ? 4'hB : `PST_MSG_SYNC;
        snapEx = exp_snap(c, 2'(q), q[2], msgT, q[3]);
        rx(2'(q), q[2], msgT, q[3], snapEx);
      end
    end
    // A write with only byte 1 enabled must leave the other bytes alone.
    @(posedge clk);
    wstrb <= 4'h2;
    wr(`PST_OFF_TSEC, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    rdc("tsecStrobe", `PST_OFF_TSEC, 32'h0000_FF20);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop();
  end
endmodule // ptp_system_time_and_snapshot_ctrl_tb
